/* File: hdl/wtpp_pkg.sv */
// wheel touch position processor: register map, reset values, scaling and timing constants
// assumes a 20 MHz system clock and an 8-bit register port with byte addresses
package wtpp_pkg;
    localparam logic [7:0] ADDR_DEBOUNCE = 8'h27;
    localparam logic [7:0] ADDR_STUCK = 8'h28;
    localparam logic [7:0] ADDR_HYST = 8'h29;
    localparam logic [7:0] ADDR_SCALE_HI = 8'h2b;
    localparam logic [7:0] ADDR_SCALE_LO = 8'h2c;
    localparam logic [7:0] ADDR_AVG_THR = 8'h2d;
    localparam logic [7:0] ADDR_NEG_THR = 8'h2e;
    localparam logic [7:0] ADDR_NEG_CNT = 8'h2f;
    localparam logic [7:0] ADDR_ROT_THR = 8'h30;
    localparam logic [7:0] ADDR_ANGLE = 8'h31;
    localparam logic [7:0] ADDR_POS_HI = 8'h40;
    localparam logic [7:0] ADDR_POS_LO = 8'h41;
    localparam logic [7:0] ADDR_STATUS = 8'h42;
    localparam logic [7:0] ADDR_PRESS_HI = 8'h43;
    localparam logic [7:0] ADDR_PRESS_LO = 8'h44;
    localparam logic [7:0] ADDR_LIMIT_HI = 8'h45;
    localparam logic [7:0] ADDR_LIMIT_LO = 8'h46;
    localparam logic [7:0] RST_DEBOUNCE = 8'h00;
    localparam logic [7:0] RST_STUCK = 8'h00;
    localparam logic [7:0] RST_HYST = 8'h03;
    localparam logic [15:0] RST_SCALE = 16'h0140;
    localparam logic [7:0] RST_AVG_THR = 8'h50;
    localparam logic [7:0] RST_NEG_THR = 8'h50;
    localparam logic [7:0] RST_NEG_CNT = 8'h01;
    localparam logic [7:0] RST_ROT_THR = 8'h02;
    localparam logic [7:0] RST_ANGLE = 8'h00;
    localparam int DEB_TOUCH_LSB = 0;
    localparam int DEB_REL_LSB = 2;
    localparam int STAT_TOUCH_BIT = 0;
    localparam int STAT_CCW_BIT = 1;
    localparam int STAT_CW_BIT = 2;
    localparam int STAT_HOLD_BIT = 3;
    localparam int THR_SHIFT = 2;
    localparam int SCALE_SHIFT = 5;
    localparam int ANGLE_SHIFT = 8;
    localparam int PERCENT_FULL = 100;
    localparam logic [7:0] AVG_SENSORS_MIN = 8'h03;
    localparam int CLK_HZ = 20000000;
    localparam int STUCK_UNIT_S = 1;
    localparam int SEC_CYCLES = CLK_HZ * STUCK_UNIT_S;
    typedef enum logic [2:0] {
        WTPP_REL = 3'b001,
        WTPP_TOUCH = 3'b010,
        WTPP_STUCK = 3'b100
    } wtpp_state_e;
endpackage : wtpp_pkg

/* File: hdl/wtpp_core.sv */
// wheel touch position processor: pressure, touch decision, position, rotation, compensation triggers
// assumes tick differences and thresholds come from logic on sys_clk_i, one sample_valid_i pulse per scan
`timescale 1ns/100ps
module wtpp_core #(
    parameter int N_SENSORS = 6,
    parameter int TICK_W = 16,
    parameter int SEC_CYCLES = wtpp_pkg::SEC_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic sample_valid_i,
    input wire logic [N_SENSORS*TICK_W-1:0] ticks_i,
    input wire logic [N_SENSORS*TICK_W-1:0] sensor_touch_threshold_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic touched_o,
    output logic cw_o,
    output logic ccw_o,
    output logic [15:0] wheel_position_o,
    output logic avg_hold_o,
    output logic comp_start_o
);
    localparam int PW = TICK_W + $clog2(N_SENSORS + 1);
    localparam int WW = PW + $clog2(N_SENSORS + 1);
    localparam int QW = WW + 16;

    logic [7:0] wheel_debounce_config;
    logic [7:0] stuck_touch_timeout;
    logic [7:0] wheel_touch_hysteresis;
    logic [7:0] wheel_scale_high;
    logic [7:0] wheel_scale_low;
    logic [7:0] averaging_hold_threshold;
    logic [7:0] negative_comp_threshold;
    logic [7:0] negative_comp_count_limit;
    logic [7:0] rotation_threshold;
    logic [7:0] wheel_angle_shift;
    logic [15:0] wheel_scale;
    logic [15:0] wheel_position_limit;
    logic [PW-1:0] wheel_pressure;

    ////////////////////////////////////////////////////////////////////////////////
    // per-sensor contributions and chained sums
    logic [PW-1:0] psum_p [0:N_SENSORS];
    logic [WW-1:0] wsum_p [0:N_SENSORS];
    logic [7:0] avg_cnt_p [0:N_SENSORS];
    logic [N_SENSORS-1:0] neg_flag;
    logic [N_SENSORS-1:0] hold_flag;
    assign psum_p[0] = '0;
    assign wsum_p[0] = '0;
    assign avg_cnt_p[0] = 8'h00;
    for (genvar i = 0; i < N_SENSORS; i++) begin : g_sensor
        logic signed [TICK_W:0] tick;
        logic signed [TICK_W:0] thr;
        logic signed [TICK_W:0] diff;
        logic signed [TICK_W:0] neg_lvl;
        logic signed [TICK_W:0] avg_lvl;
        logic [TICK_W-1:0] contrib;
        assign tick = {ticks_i[i*TICK_W+TICK_W-1], ticks_i[i*TICK_W +: TICK_W]};
        assign thr = {1'b0, sensor_touch_threshold_i[i*TICK_W +: TICK_W]};
        assign diff = tick - thr;
        assign contrib = (diff > 0) ? diff[TICK_W-1:0] : '0;
        assign neg_lvl = (TICK_W+1)'({negative_comp_threshold, 2'b00});
        assign avg_lvl = (TICK_W+1)'({averaging_hold_threshold, 2'b00});
        assign neg_flag[i] = (tick + neg_lvl) < 0;
        assign hold_flag[i] = tick > avg_lvl;
        assign psum_p[i+1] = psum_p[i] + PW'(contrib);
        assign wsum_p[i+1] = wsum_p[i] + WW'(WW'(contrib) * WW'(i));
        assign avg_cnt_p[i+1] = avg_cnt_p[i] + ((tick >= avg_lvl) ? 8'h01 : 8'h00);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // first stage: capture sums of one completed scan
    logic s1_valid;
    logic [WW-1:0] wsum_q;
    logic neg_any_q;
    logic [7:0] avg_cnt_q;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_valid <= 1'b0;
            wheel_pressure <= '0;
            wsum_q <= '0;
            neg_any_q <= 1'b0;
            avg_cnt_q <= 8'h00;
            avg_hold_o <= 1'b0;
        end else if (ce_i) begin
            s1_valid <= sample_valid_i;
            if (sample_valid_i) begin
                wheel_pressure <= psum_p[N_SENSORS];
                wsum_q <= wsum_p[N_SENSORS];
                neg_any_q <= |neg_flag;
                avg_cnt_q <= avg_cnt_p[N_SENSORS];
                avg_hold_o <= |hold_flag;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // position, offset and rotation arithmetic
    logic [31:0] limit_full;
    logic [QW-1:0] num;
    logic [QW-1:0] den;
    logic [QW-1:0] quot;
    logic [15:0] raw_pos;
    logic [23:0] off_full;
    logic [16:0] pos_sum;
    logic [15:0] pos_adj;
    logic [23:0] rot_full;
    logic [15:0] rot_thr;
    logic [16:0] fwd_diff;
    logic [15:0] fwd;
    logic [15:0] bwd;
    logic pressure_zero;
    logic pressure_over;
    logic cw_det;
    logic ccw_det;
    assign wheel_scale = {wheel_scale_high, wheel_scale_low};
    assign limit_full = {16'h0000, wheel_scale} * 32'(N_SENSORS);
    assign wheel_position_limit = limit_full[wtpp_pkg::SCALE_SHIFT +: 16];
    assign num = QW'(wheel_scale) * QW'(wsum_q);
    assign den = QW'({wheel_pressure, 5'b00000});
    assign quot = (den == '0) ? '0 : num / den;
    assign raw_pos = quot[15:0];
    assign off_full = {16'h0000, wheel_angle_shift} * {8'h00, wheel_position_limit};
    assign pos_sum = {1'b0, raw_pos} + {1'b0, off_full[wtpp_pkg::ANGLE_SHIFT +: 16]};
    assign pos_adj = (pos_sum >= {1'b0, wheel_position_limit} && wheel_position_limit != 16'h0000) ?
                     16'(pos_sum - {1'b0, wheel_position_limit}) : pos_sum[15:0];
    assign rot_full = ({16'h0000, rotation_threshold} * {8'h00, wheel_position_limit}) /
                      24'(wtpp_pkg::PERCENT_FULL);
    assign rot_thr = rot_full[15:0];
    assign pressure_zero = (wheel_pressure == '0);
    assign pressure_over = wheel_pressure > PW'({wheel_touch_hysteresis, 2'b00});

    logic [15:0] pos_prev;
    logic prev_valid;
    wtpp_pkg::wtpp_state_e state;
    assign fwd_diff = {1'b0, pos_adj} - {1'b0, pos_prev};
    assign fwd = fwd_diff[16] ? 16'(fwd_diff + {1'b0, wheel_position_limit}) : fwd_diff[15:0];
    assign bwd = (fwd == 16'h0000) ? 16'h0000 : 16'(wheel_position_limit - fwd);
    assign cw_det = (fwd <= (wheel_position_limit >> 1)) && (fwd > rot_thr);
    assign ccw_det = (fwd > (wheel_position_limit >> 1)) && (bwd > rot_thr);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wheel_position_o <= 16'h0000;
            pos_prev <= 16'h0000;
            prev_valid <= 1'b0;
            cw_o <= 1'b0;
            ccw_o <= 1'b0;
        end else if (ce_i && s1_valid) begin
            cw_o <= 1'b0;
            ccw_o <= 1'b0;
            if (!pressure_zero) begin
                wheel_position_o <= pos_adj;
                pos_prev <= pos_adj;
                prev_valid <= 1'b1;
                if (prev_valid && state == wtpp_pkg::WTPP_TOUCH) begin
                    cw_o <= cw_det;
                    ccw_o <= ccw_det;
                end
            end else begin
                prev_valid <= 1'b0;
            end
        end else if (ce_i && state != wtpp_pkg::WTPP_TOUCH) begin
            // a forced release must not leave a stale rotation status behind
            cw_o <= 1'b0;
            ccw_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // stuck-touch timer, whole seconds while touched
    logic [$clog2(SEC_CYCLES+1)-1:0] cyc_cnt;
    logic [7:0] sec_cnt;
    logic stuck_fire;
    assign stuck_fire = (stuck_touch_timeout != 8'h00) && (sec_cnt >= stuck_touch_timeout);
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cyc_cnt <= '0;
            sec_cnt <= 8'h00;
        end else if (ce_i) begin
            if (state != wtpp_pkg::WTPP_TOUCH) begin
                cyc_cnt <= '0;
                sec_cnt <= 8'h00;
            end else if (cyc_cnt == ($bits(cyc_cnt))'(SEC_CYCLES - 1)) begin
                cyc_cnt <= '0;
                if (sec_cnt != 8'hff) begin
                    sec_cnt <= sec_cnt + 8'h01;
                end
            end else begin
                cyc_cnt <= cyc_cnt + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // touch / release decision with debounce
    logic [2:0] touch_need;
    logic [2:0] rel_need;
    logic [2:0] touch_cnt;
    logic [2:0] rel_cnt;
    assign touch_need = {1'b0, wheel_debounce_config[wtpp_pkg::DEB_TOUCH_LSB +: 2]} + 3'h1;
    assign rel_need = {1'b0, wheel_debounce_config[wtpp_pkg::DEB_REL_LSB +: 2]} + 3'h1;
    assign touched_o = (state == wtpp_pkg::WTPP_TOUCH);
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= wtpp_pkg::WTPP_REL;
            touch_cnt <= 3'h0;
            rel_cnt <= 3'h0;
        end else if (ce_i) begin
            case (state)
                wtpp_pkg::WTPP_REL: begin
                    rel_cnt <= 3'h0;
                    if (s1_valid) begin
                        if (!pressure_over) begin
                            touch_cnt <= 3'h0;
                        end else if (touch_cnt + 3'h1 >= touch_need) begin
                            state <= wtpp_pkg::WTPP_TOUCH;
                            touch_cnt <= 3'h0;
                        end else begin
                            touch_cnt <= touch_cnt + 3'h1;
                        end
                    end
                end
                wtpp_pkg::WTPP_TOUCH, wtpp_pkg::WTPP_STUCK: begin
                    touch_cnt <= 3'h0;
                    if (state == wtpp_pkg::WTPP_TOUCH && stuck_fire) begin
                        state <= wtpp_pkg::WTPP_STUCK;
                        rel_cnt <= 3'h0;
                    end else if (s1_valid) begin
                        if (!pressure_zero) begin
                            rel_cnt <= 3'h0;
                        end else if (rel_cnt + 3'h1 >= rel_need) begin
                            state <= wtpp_pkg::WTPP_REL;
                            rel_cnt <= 3'h0;
                        end else begin
                            rel_cnt <= rel_cnt + 3'h1;
                        end
                    end
                end
                default: begin
                    state <= wtpp_pkg::WTPP_REL;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // offset compensation triggers
    logic [7:0] neg_cnt;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            neg_cnt <= 8'h00;
            comp_start_o <= 1'b0;
        end else if (ce_i) begin
            comp_start_o <= 1'b0;
            if (s1_valid) begin
                if (!neg_any_q) begin
                    neg_cnt <= 8'h00;
                end else if (neg_cnt + 8'h01 >= negative_comp_count_limit) begin
                    neg_cnt <= 8'h00;
                    comp_start_o <= 1'b1;
                end else begin
                    neg_cnt <= neg_cnt + 8'h01;
                end
                if (avg_cnt_q >= wtpp_pkg::AVG_SENSORS_MIN) begin
                    comp_start_o <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register port
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wheel_debounce_config <= wtpp_pkg::RST_DEBOUNCE;
            stuck_touch_timeout <= wtpp_pkg::RST_STUCK;
            wheel_touch_hysteresis <= wtpp_pkg::RST_HYST;
            wheel_scale_high <= wtpp_pkg::RST_SCALE[15:8];
            wheel_scale_low <= wtpp_pkg::RST_SCALE[7:0];
            averaging_hold_threshold <= wtpp_pkg::RST_AVG_THR;
            negative_comp_threshold <= wtpp_pkg::RST_NEG_THR;
            negative_comp_count_limit <= wtpp_pkg::RST_NEG_CNT;
            rotation_threshold <= wtpp_pkg::RST_ROT_THR;
            wheel_angle_shift <= wtpp_pkg::RST_ANGLE;
        end else if (ce_i && reg_wr_i) begin
            if (reg_addr_i == wtpp_pkg::ADDR_DEBOUNCE) begin
                wheel_debounce_config <= {4'h0, reg_wdata_i[3:0]};
            end else if (reg_addr_i == wtpp_pkg::ADDR_STUCK) begin
                stuck_touch_timeout <= reg_wdata_i;
            end else if (reg_addr_i == wtpp_pkg::ADDR_HYST) begin
                wheel_touch_hysteresis <= reg_wdata_i;
            end else if (reg_addr_i == wtpp_pkg::ADDR_SCALE_HI) begin
                wheel_scale_high <= reg_wdata_i;
            end else if (reg_addr_i == wtpp_pkg::ADDR_SCALE_LO) begin
                wheel_scale_low <= reg_wdata_i;
            end else if (reg_addr_i == wtpp_pkg::ADDR_AVG_THR) begin
                averaging_hold_threshold <= reg_wdata_i;
            end else if (reg_addr_i == wtpp_pkg::ADDR_NEG_THR) begin
                negative_comp_threshold <= reg_wdata_i;
            end else if (reg_addr_i == wtpp_pkg::ADDR_NEG_CNT) begin
                negative_comp_count_limit <= reg_wdata_i;
            end else if (reg_addr_i == wtpp_pkg::ADDR_ROT_THR) begin
                rotation_threshold <= reg_wdata_i;
            end else if (reg_addr_i == wtpp_pkg::ADDR_ANGLE) begin
                wheel_angle_shift <= reg_wdata_i;
            end
        end
    end

    logic [15:0] press16;
    logic [7:0] status;
    assign press16 = (wheel_pressure > PW'(16'hffff)) ? 16'hffff : wheel_pressure[15:0];
    assign status = {4'h0, avg_hold_o, cw_o, ccw_o, touched_o};
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (ce_i && reg_rd_i) begin
            if (reg_addr_i == wtpp_pkg::ADDR_DEBOUNCE) reg_rdata_o <= wheel_debounce_config;
            else if (reg_addr_i == wtpp_pkg::ADDR_STUCK) reg_rdata_o <= stuck_touch_timeout;
            else if (reg_addr_i == wtpp_pkg::ADDR_HYST) reg_rdata_o <= wheel_touch_hysteresis;
            else if (reg_addr_i == wtpp_pkg::ADDR_SCALE_HI) reg_rdata_o <= wheel_scale_high;
            else if (reg_addr_i == wtpp_pkg::ADDR_SCALE_LO) reg_rdata_o <= wheel_scale_low;
            else if (reg_addr_i == wtpp_pkg::ADDR_AVG_THR) reg_rdata_o <= averaging_hold_threshold;
            else if (reg_addr_i == wtpp_pkg::ADDR_NEG_THR) reg_rdata_o <= negative_comp_threshold;
            else if (reg_addr_i == wtpp_pkg::ADDR_NEG_CNT) reg_rdata_o <= negative_comp_count_limit;
            else if (reg_addr_i == wtpp_pkg::ADDR_ROT_THR) reg_rdata_o <= rotation_threshold;
            else if (reg_addr_i == wtpp_pkg::ADDR_ANGLE) reg_rdata_o <= wheel_angle_shift;
            else if (reg_addr_i == wtpp_pkg::ADDR_POS_HI) reg_rdata_o <= wheel_position_o[15:8];
            else if (reg_addr_i == wtpp_pkg::ADDR_POS_LO) reg_rdata_o <= wheel_position_o[7:0];
            else if (reg_addr_i == wtpp_pkg::ADDR_STATUS) reg_rdata_o <= status;
            else if (reg_addr_i == wtpp_pkg::ADDR_PRESS_HI) reg_rdata_o <= press16[15:8];
            else if (reg_addr_i == wtpp_pkg::ADDR_PRESS_LO) reg_rdata_o <= press16[7:0];
            else if (reg_addr_i == wtpp_pkg::ADDR_LIMIT_HI) reg_rdata_o <= wheel_position_limit[15:8];
            else if (reg_addr_i == wtpp_pkg::ADDR_LIMIT_LO) reg_rdata_o <= wheel_position_limit[7:0];
            else reg_rdata_o <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    property p_touch_cause;
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(touched_o) |-> $past(pressure_over) && $past(s1_valid);
    endproperty
    a_touch_cause: assert property (p_touch_cause) else $error("touch without pressure over hysteresis");

    property p_release_cause;
        @(posedge sys_clk_i) disable iff (rst_i)
        $fell(touched_o) && !$past(stuck_fire) |-> $past(pressure_zero) && $past(s1_valid);
    endproperty
    a_release_cause: assert property (p_release_cause) else $error("release without zero pressure");

    property p_no_debounce;
        @(posedge sys_clk_i) disable iff (rst_i)
        ce_i && s1_valid && state == wtpp_pkg::WTPP_REL && pressure_over && wheel_debounce_config[1:0] == 2'b00
        |=> touched_o;
    endproperty
    a_no_debounce: assert property (p_no_debounce) else $error("undebounced touch not immediate");

    property p_pos_range;
        @(posedge sys_clk_i) disable iff (rst_i)
        s1_valid && !pressure_zero && wheel_position_limit != 16'h0000 && raw_pos < wheel_position_limit
        |-> pos_adj < wheel_position_limit;
    endproperty
    a_pos_range: assert property (p_pos_range) else $error("position outside range");

    property p_zero_shift;
        @(posedge sys_clk_i) disable iff (rst_i)
        s1_valid && wheel_angle_shift == 8'h00 && raw_pos < wheel_position_limit |-> pos_adj == raw_pos;
    endproperty
    a_zero_shift: assert property (p_zero_shift) else $error("zero angle shift changed position");

    property p_rot_exclusive;
        @(posedge sys_clk_i) disable iff (rst_i)
        (cw_o || ccw_o) |-> !(cw_o && ccw_o) && (touched_o || $past(touched_o));
    endproperty
    a_rot_exclusive: assert property (p_rot_exclusive) else $error("rotation flags inconsistent");

    property p_neg_comp;
        @(posedge sys_clk_i) disable iff (rst_i)
        ce_i && s1_valid && neg_any_q && negative_comp_count_limit == 8'h01 |=> comp_start_o;
    endproperty
    a_neg_comp: assert property (p_neg_comp) else $error("negative ticks did not start compensation");

    property p_avg_comp;
        @(posedge sys_clk_i) disable iff (rst_i)
        ce_i && s1_valid && avg_cnt_q >= wtpp_pkg::AVG_SENSORS_MIN
        |=> comp_start_o ##1 (!comp_start_o || $past(s1_valid) || !$past(ce_i));
    endproperty
    a_avg_comp: assert property (p_avg_comp) else $error("three held sensors did not start compensation");

    property p_stuck_release;
        @(posedge sys_clk_i) disable iff (rst_i)
        ce_i && touched_o && stuck_fire |=> !touched_o && state == wtpp_pkg::WTPP_STUCK;
    endproperty
    a_stuck_release: assert property (p_stuck_release) else $error("stuck timeout did not force release");
endmodule : wtpp_core

/* File: dv/wtpp_front_model.sv */
// capacitive front end model: one scan every SCAN cycles, one sensor carries ticks
// assumes the bench picks the touched sensor and its tick level
`timescale 1ns/100ps
module wtpp_front_model #(
    parameter int SCAN = 8,
    parameter int THR = 50
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [2:0] k_i,
    input wire logic signed [15:0] amp_i,
    output logic sample_valid_o,
    output logic [95:0] ticks_o,
    output logic [95:0] thr_o
);
    int cnt;
    logic [95:0] pat;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= 0;
        end else begin
            cnt <= (cnt == SCAN - 1) ? 0 : cnt + 1;
        end
    end
    assign sample_valid_o = (cnt == SCAN - 1);
    always_comb begin
        pat = '0;
        pat[k_i*16 +: 16] = amp_i;
        // outside a scan the bus carries the inverted pattern
        ticks_o = sample_valid_o ? pat : ~pat;
        thr_o = {6{16'(THR)}};
    end
endmodule : wtpp_front_model

/* File: dv/testbench.sv */
// random and corner-case bench for the wheel processor
// assumes the front end model and a short stuck-touch second
`timescale 1ns/100ps
module testbench;
    localparam int LIM = int'(wtpp_pkg::RST_SCALE) * 6 / 32;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic ce = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [2:0] k = 3'h0;
    logic signed [15:0] amp = 16'sh0;
    logic sv, touched, cw, ccw, hold, comp;
    logic [95:0] ticks, thr;
    logic [7:0] rdata;
    logic [15:0] pos;
    int n_fail = 0;
    int compares = 0;
    int seed = 32'h38e8;
    always #25 sys_clk_i = ~sys_clk_i;
    wtpp_front_model wtpp_front_model_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .k_i(k), .amp_i(amp),
        .sample_valid_o(sv), .ticks_o(ticks), .thr_o(thr));
    wtpp_core #(.SEC_CYCLES(10)) wtpp_core_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce),
        .sample_valid_i(sv), .ticks_i(ticks), .sensor_touch_threshold_i(thr), .reg_addr_i(addr),
        .reg_wr_i(reg_wr), .reg_wdata_i(wdata), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .touched_o(touched),
        .cw_o(cw), .ccw_o(ccw), .wheel_position_o(pos), .avg_hold_o(hold), .comp_start_o(comp));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        #1;
        addr = a;
        wdata = d;
        reg_wr = 1'b1;
        @(posedge sys_clk_i);
        #1;
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        #1;
        addr = a;
        reg_rd = 1'b1;
        @(posedge sys_clk_i);
        #1;
        reg_rd = 1'b0;
        check(16'(rdata), 16'(e));
    endtask : rd
    // load one scan pattern and wait until its results are visible
    task automatic smp(input int kk, input int a);
        @(posedge sys_clk_i);
        #1;
        k = 3'(kk);
        amp = 16'(a);
        while (sv !== 1'b1) begin
            @(posedge sys_clk_i);
            #1;
        end
        repeat (2) @(posedge sys_clk_i);
        #1;
    endtask : smp
    function automatic logic [1:0] rot(input int p, input int c);
        int f;
        f = (c - p + LIM) % LIM;
        if (p < 0) return 2'b00;
        return {f <= LIM / 2 && f > LIM * 2 / 100, f > LIM / 2 && LIM - f > LIM * 2 / 100};
    endfunction : rot
    initial begin
        int kk;
        int prev;
        repeat (5) @(posedge sys_clk_i);
        #1;
        rst_i = 1'b0;
        rd(wtpp_pkg::ADDR_HYST, wtpp_pkg::RST_HYST);
        rd(wtpp_pkg::ADDR_SCALE_HI, 8'h01);
        rd(wtpp_pkg::ADDR_SCALE_LO, 8'h40);
        rd(wtpp_pkg::ADDR_ANGLE, 8'h00);
        rd(wtpp_pkg::ADDR_ROT_THR, 8'h02);
        rd(8'hff, 8'h00);
        $display("test registers done");
        smp(1, 150);
        check(16'(touched), 16'h1);
        check(pos, 16'h000a);
        rd(wtpp_pkg::ADDR_POS_HI, 8'h00);
        rd(wtpp_pkg::ADDR_POS_LO, 8'h0a);
        rd(wtpp_pkg::ADDR_PRESS_LO, 8'h64);
        rd(wtpp_pkg::ADDR_LIMIT_LO, 8'(LIM));
        rd(wtpp_pkg::ADDR_STATUS, 8'h01);
        smp(1, 0);
        check(16'(touched), 16'h0);
        wr(wtpp_pkg::ADDR_DEBOUNCE, 8'h01);
        smp(2, 150);
        check(16'(touched), 16'h0);
        smp(2, 150);
        check(16'(touched), 16'h1);
        wr(wtpp_pkg::ADDR_DEBOUNCE, 8'h04);
        smp(2, 0);
        check(16'(touched), 16'h1);
        smp(2, 0);
        check(16'(touched), 16'h0);
        wr(wtpp_pkg::ADDR_DEBOUNCE, 8'h00);
        wr(wtpp_pkg::ADDR_HYST, 8'h19);
        smp(2, 150);
        check(16'(touched), 16'h0);
        wr(wtpp_pkg::ADDR_HYST, wtpp_pkg::RST_HYST);
        prev = -1;
        for (int i = 0; i < 16; i++) begin
            kk = ($random(seed) & 32'h7fff) % 6;
            smp(kk, 64 + ($random(seed) & 32'hff));
            check(pos, 16'(kk * LIM / 6));
            check(16'({cw, ccw}), 16'(rot(prev, kk * LIM / 6)));
            prev = kk * LIM / 6;
        end
        $display("test position done");
        wr(wtpp_pkg::ADDR_ANGLE, 8'h40);
        smp(5, 150);
        check(pos, 16'((5 * LIM / 6 + 64 * LIM / 256) % LIM));
        wr(wtpp_pkg::ADDR_STUCK, 8'h01);
        smp(5, 150);
        smp(5, 150);
        check(16'(touched), 16'h0);
        smp(5, 0);
        smp(5, 150);
        check(16'(touched), 16'h1);
        smp(0, 400);
        check(16'(hold), 16'h1);
        smp(0, -400);
        check(16'(comp), 16'h1);
        wr(wtpp_pkg::ADDR_AVG_THR, 8'h00);
        smp(1, 150);
        check(16'(comp), 16'h1);
        ce = 1'b0;
        wr(wtpp_pkg::ADDR_ANGLE, 8'h80);
        ce = 1'b1;
        rd(wtpp_pkg::ADDR_ANGLE, 8'h40);
        $display("test compensation done");
        conclude();
    end
    initial begin
        repeat (6000) @(posedge sys_clk_i);
        n_fail++;
        conclude();
    end
endmodule : testbench
